// [hw/selvc_pkg.sv]
// Package for the secondary error log and VC capability register bank.
// Assumes a dword-aligned 12-bit configuration byte address from the host.
package selvc_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_SEV = 12'h134;
	localparam logic [11:0] OFS_CAP = 12'h138;
	localparam logic [11:0] OFS_LOG0 = 12'h13C;
	localparam logic [11:0] OFS_LOG1 = 12'h140;
	localparam logic [11:0] OFS_LOG2 = 12'h144;
	localparam logic [11:0] OFS_LOG3 = 12'h148;
	localparam logic [11:0] OFS_RSVD = 12'h14C;
	localparam logic [11:0] OFS_VCHDR = 12'h150;
	localparam logic [11:0] OFS_PCAP1 = 12'h154;
	localparam logic [11:0] OFS_PCAP2 = 12'h158;
	localparam logic [11:0] OFS_PCTLST = 12'h15C;
	localparam logic [11:0] OFS_V0CAP = 12'h160;
	localparam logic [11:0] OFS_V0CTL = 12'h164;
	localparam logic [11:0] OFS_V0ST = 12'h168;
	// Severity field layout
	localparam int SEV_W = 14;
	localparam logic [13:0] SEV_WMASK = 14'h3FEF;
	localparam logic [13:0] SEV_RST = 14'h1340;
	// First-error pointer width
	localparam int PTR_W = 5;
	// VC capability header fields
	localparam logic [15:0] VC_CAP_ID = 16'h0002;
	localparam logic [3:0] VC_CAP_VER = 4'h1;
	localparam logic [11:0] VC_NEXT_PTR = 12'h000;
	// Channel_zero_resource_control fields
	localparam int TCMAP_LSB = 1;
	localparam int TCMAP_W = 7;
	localparam logic [6:0] TCMAP_RST = 7'h7F;
	localparam logic TCMAP_TC0 = 1'b1;
	localparam int VC_EN_BIT = 31;
	localparam logic VC_EN_VAL = 1'b1;
	// Header log word 1 field positions
	localparam int LOG1_CMDLO_LSB = 4;
	localparam int LOG1_CMDHI_LSB = 8;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// Configuration request from the host
	typedef struct packed {
		logic rd;          // Read strobe
		logic wr;          // Write strobe
		logic [11:0] addr; // Byte address
		logic [3:0] be;    // Byte enables
		logic [31:0] wdata; // Write data
	} selvc_cfg_req_t;

	// Transaction fields of the failing secondary transaction
	typedef struct packed {
		logic [3:0] attr_cbe;  // Byte enables in attribute phase
		logic [31:0] attr_ad;  // Address/data in attribute phase
		logic [3:0] cmd_lo;    // Command in first address phase
		logic [3:0] cmd_hi;    // Command in second address phase
		logic [31:0] addr_lo;  // Address in first address phase
		logic [31:0] addr_hi;  // Address in second address phase
		logic dac;             // Dual address cycle used
	} selvc_txn_t;
endpackage

// [hw/selvc_bank.sv]
// Secondary error severity, first-error pointer, header log and VC0 capability.
// Assumes error events, mask and status-release come from same-clock bridge logic.
//
// How it works
// - Severity bits 0-3,5-13 writable, defined reset pattern
// - First-error pointer five bits, read-only, resets zero
// - Log bits 35:0 hold attribute-phase CBE and AD
// - Log bits 39:36 hold first-phase command
// - Log bits 43:40 DAC command; 63:44 zero
// - Log bits 95:64 hold first-phase address
// - Log bits 127:96 hold second-phase DAC address
// - VC header identifier reads 0002h
// - VC header version reads one
// - Next capability pointer reads zero
// - Port VC capability one reads zero
// - Port VC capability two reads zero
// - Port_channel_control read-only zero
// - Port_channel_status reads zero
// - VC0 resource capability reads zero
// - TC map bit0 one, 7:1 writable, enable one
// - Channel_zero_resource_status reads zero
`timescale 1ns/1ps
module selvc_bank (
	input wire logic mclk,                        // 20 MHz clock
	input wire logic reset,                       // Synchronous reset, active high
	input wire logic mclk_en,                     // Clock enable, freezes state when low
	input wire selvc_pkg::selvc_cfg_req_t cfg_req, // Configuration request
	output logic [31:0] cfg_rdata,                // Read data, registered
	output logic cfg_rvalid,                      // Read data valid pulse
	input wire logic [13:0] err_evt,              // Error event pulses per type
	input wire logic [13:0] err_mask,             // Mask per type, high masks
	input wire selvc_pkg::selvc_txn_t txn,        // Failing transaction fields
	input wire logic log_release,                 // Status cleared, log may rearm
	output logic err_fatal,                       // Fatal report pulse
	output logic err_nonfatal,                    // Non-fatal report pulse
	output logic log_held                         // Log holds a captured error
);
	// Severity bits, sticky
	logic [13:0] sev_ff;
	// First-error pointer
	logic [4:0] ptr_ff;
	// Header log fields
	selvc_pkg::selvc_txn_t log_ff;
	// Log held flag
	logic held_ff;
	// Writable part of the TC map
	logic [6:0] tcmap_ff;
	// Report pulses
	logic fatal_ff;
	logic nonfatal_ff;
	// Read path registers
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic [31:0] nxt_rdata;
	// Qualified events
	logic [13:0] live_evt;
	logic [4:0] nxt_ptr;
	logic wr_sev;
	logic wr_v0ctl;

	// Only unmasked, implemented error types take part
	assign live_evt = err_evt & ~err_mask & selvc_pkg::SEV_WMASK;
	assign wr_sev = cfg_req.wr && cfg_req.addr == selvc_pkg::OFS_SEV;
	assign wr_v0ctl = cfg_req.wr && cfg_req.addr == selvc_pkg::OFS_V0CTL;

	// Lowest set index wins when several errors land together
	always_comb begin
		nxt_ptr = 5'h00;
		for (int i = selvc_pkg::SEV_W - 1; i >= 0; i--) begin
			if (live_evt[i]) begin
				nxt_ptr = 5'(i);
			end
		end
	end

	// One sticky severity bit per error type, written per byte lane
	genvar g;
	generate
		for (g = 0; g < selvc_pkg::SEV_W; g++) begin : gen_sev
			if (selvc_pkg::SEV_WMASK[g]) begin : gen_wr
				always_ff @(posedge mclk) begin
					if (reset) begin
						sev_ff[g] <= selvc_pkg::SEV_RST[g];
					end else if (mclk_en && wr_sev && cfg_req.be[g / 8]) begin
						sev_ff[g] <= cfg_req.wdata[g];
					end
				end
			end else begin : gen_ro
				// Bit 4 is reserved and stays zero
				assign sev_ff[g] = 1'b0;
			end
		end
	endgenerate

	// Logging: first unmasked error freezes pointer and header log
	always_ff @(posedge mclk) begin
		if (reset) begin
			held_ff <= 1'b0;
			ptr_ff <= 5'h00;
			log_ff <= '0;
		end else if (mclk_en) begin
			// A new error beats a release in the same cycle, so none is lost
			if (|live_evt && (!held_ff || log_release)) begin
				held_ff <= 1'b1;
				ptr_ff <= nxt_ptr;
				log_ff.attr_cbe <= txn.attr_cbe;
				log_ff.attr_ad <= txn.attr_ad;
				log_ff.cmd_lo <= txn.cmd_lo;
				log_ff.addr_lo <= txn.addr_lo;
				// Second-phase fields only mean something for DAC
				log_ff.cmd_hi <= txn.dac ? txn.cmd_hi : 4'h0;
				log_ff.addr_hi <= txn.dac ? txn.addr_hi : 32'h0000_0000;
				// Kept so the log knows which second-phase fields are real
				log_ff.dac <= txn.dac;
			end else if (log_release) begin
				// Pointer and log stay readable until the next capture
				held_ff <= 1'b0;
			end
		end
	end

	// Severity steers each reported error into fatal or non-fatal
	always_ff @(posedge mclk) begin
		if (reset) begin
			fatal_ff <= 1'b0;
			nonfatal_ff <= 1'b0;
		end else if (mclk_en) begin
			fatal_ff <= |(live_evt & sev_ff);
			nonfatal_ff <= |(live_evt & ~sev_ff);
		end
	end

	// Writable TC map bits 7:1 of Channel_zero_resource_control
	always_ff @(posedge mclk) begin
		if (reset) begin
			tcmap_ff <= selvc_pkg::TCMAP_RST;
		end else if (mclk_en && wr_v0ctl && cfg_req.be[0]) begin
			tcmap_ff <= cfg_req.wdata[7:1];
		end
	end

	// Read decode; fixed VC words are constants, unmapped reads give zero
	always_comb begin
		nxt_rdata = selvc_pkg::ZERO_WORD;
		case (cfg_req.addr)
			selvc_pkg::OFS_SEV: begin
				nxt_rdata[13:0] = sev_ff;
			end
			selvc_pkg::OFS_CAP: begin
				nxt_rdata[4:0] = ptr_ff;
			end
			selvc_pkg::OFS_LOG0: begin
				nxt_rdata = log_ff.attr_ad;
			end
			// This word packs the attribute CBE and both command nibbles
			selvc_pkg::OFS_LOG1: begin
				nxt_rdata[3:0] = log_ff.attr_cbe;
				nxt_rdata[7:4] = log_ff.cmd_lo;
				nxt_rdata[11:8] = log_ff.cmd_hi;
			end
			selvc_pkg::OFS_LOG2: begin
				nxt_rdata = log_ff.addr_lo;
			end
			selvc_pkg::OFS_LOG3: begin
				nxt_rdata = log_ff.addr_hi;
			end
			selvc_pkg::OFS_RSVD: begin
				nxt_rdata = selvc_pkg::ZERO_WORD;
			end
			selvc_pkg::OFS_VCHDR: begin
				nxt_rdata = {selvc_pkg::VC_NEXT_PTR,
					selvc_pkg::VC_CAP_VER,
					selvc_pkg::VC_CAP_ID};
			end
			selvc_pkg::OFS_PCAP1: begin
				nxt_rdata = selvc_pkg::ZERO_WORD;
			end
			selvc_pkg::OFS_PCAP2: begin
				nxt_rdata = selvc_pkg::ZERO_WORD;
			end
			selvc_pkg::OFS_PCTLST: begin
				nxt_rdata = selvc_pkg::ZERO_WORD;
			end
			selvc_pkg::OFS_V0CAP: begin
				nxt_rdata = selvc_pkg::ZERO_WORD;
			end
			selvc_pkg::OFS_V0CTL: begin
				nxt_rdata[0] = selvc_pkg::TCMAP_TC0;
				nxt_rdata[7:1] = tcmap_ff;
				nxt_rdata[selvc_pkg::VC_EN_BIT] = selvc_pkg::VC_EN_VAL;
			end
			selvc_pkg::OFS_V0ST: begin
				nxt_rdata = selvc_pkg::ZERO_WORD;
			end
			default: begin
				nxt_rdata = selvc_pkg::ZERO_WORD;
			end
		endcase
	end

	// Read data lands one cycle after the strobe
	// Valid holds while the enable is low, so a host must not count frozen cycles
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_ff <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else if (mclk_en) begin
			rvalid_ff <= cfg_req.rd;
			if (cfg_req.rd) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	assign cfg_rdata = rdata_ff;
	assign cfg_rvalid = rvalid_ff;
	assign err_fatal = fatal_ff;
	assign err_nonfatal = nonfatal_ff;
	assign log_held = held_ff;

	// Checks on the bank's outputs and internal registers
	// All checks run on mclk and are switched off while reset is high
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_SEV_RSVD: assert property (
		cfg_rvalid && $past(cfg_req.addr) == selvc_pkg::OFS_SEV && $past(mclk_en)
		|-> cfg_rdata[31:14] == 18'h0_0000 && cfg_rdata[4] == 1'b0)
		else $error("Severity reserved bits not zero");
	AST_PTR_LOAD: assert property (
		mclk_en && |live_evt && !held_ff |=> log_held && ptr_ff == $past(nxt_ptr))
		else $error("First error pointer not loaded");
	AST_LOG_FROZEN: assert property (
		mclk_en && held_ff && !log_release |=> $stable(log_ff) && $stable(ptr_ff))
		else $error("Header log changed while held");
	AST_DAC_HI: assert property (
		mclk_en && |live_evt && !held_ff && !txn.dac |=> log_ff.addr_hi == 32'h0000_0000)
		else $error("Second address logged without DAC");
	AST_VCHDR: assert property (
		mclk_en && cfg_req.rd && cfg_req.addr == selvc_pkg::OFS_VCHDR
		|=> cfg_rvalid && cfg_rdata == 32'h0001_0002)
		else $error("VC header value wrong");
	AST_FIXED_ZERO: assert property (
		mclk_en && cfg_req.rd && (cfg_req.addr == selvc_pkg::OFS_V0CAP
		|| cfg_req.addr == selvc_pkg::OFS_V0ST || cfg_req.addr == selvc_pkg::OFS_PCTLST)
		|=> cfg_rdata == 32'h0000_0000)
		else $error("Fixed VC word not zero");
	AST_V0CTL: assert property (
		mclk_en && cfg_req.rd && cfg_req.addr == selvc_pkg::OFS_V0CTL
		|=> cfg_rdata[0] && cfg_rdata[31] && cfg_rdata[30:8] == 23'h00_0000)
		else $error("VC0 control fixed bits wrong");
	AST_FATAL: assert property (
		mclk_en && |(live_evt & sev_ff) |=> err_fatal)
		else $error("Fatal error not reported");
	AST_NONFATAL: assert property (
		mclk_en && live_evt != 14'h0000 && (live_evt & sev_ff) == 14'h0000
		|=> err_nonfatal && !err_fatal)
		else $error("Non-fatal error misreported");
	AST_RSVD_WORD: assert property (
		mclk_en && cfg_req.rd && cfg_req.addr == selvc_pkg::OFS_RSVD |=> cfg_rdata == 32'h0)
		else $error("Reserved word not zero");

	// Capture must take the lowest unmasked index, not just any set one
	AST_PTR_LOWEST: assert property (
		mclk_en && |live_evt && !held_ff
		|=> (($past(live_evt) >> ptr_ff) & 14'h0001) == 14'h0001
		&& ($past(live_evt) & ~(14'h3FFF << ptr_ff)) == 14'h0000)
		else $error("First error pointer not the lowest index");
	// Attribute and first address phase fields come straight from the event cycle
	AST_LOG_CAPTURE: assert property (
		mclk_en && |live_evt && (!held_ff || log_release)
		|=> log_ff.attr_ad == $past(txn.attr_ad)
		&& log_ff.attr_cbe == $past(txn.attr_cbe)
		&& log_ff.cmd_lo == $past(txn.cmd_lo)
		&& log_ff.addr_lo == $past(txn.addr_lo))
		else $error("Header log first phase fields wrong");
	// A dual address cycle must keep both second-phase fields
	AST_DAC_LOG: assert property (
		mclk_en && |live_evt && (!held_ff || log_release) && txn.dac
		|=> log_ff.dac && log_ff.cmd_hi == $past(txn.cmd_hi)
		&& log_ff.addr_hi == $past(txn.addr_hi))
		else $error("Second phase fields not logged");
	// A held log stays held until software releases it
	AST_HELD_KEEP: assert property (
		mclk_en && held_ff && !log_release |=> log_held)
		else $error("Log dropped without release");
	// Bits 3:0 of a byte lane 0 severity write land, the reserved bit does not
	AST_SEV_WRITE: assert property (
		mclk_en && wr_sev && cfg_req.be[0]
		|=> sev_ff[3:0] == $past(cfg_req.wdata[3:0]) && !sev_ff[4])
		else $error("Severity write did not land");
	// Only bits 7:1 of the TC map follow a write
	AST_TC_WRITE: assert property (
		mclk_en && wr_v0ctl && cfg_req.be[0]
		|=> tcmap_ff == $past(cfg_req.wdata[7:1]))
		else $error("TC map write did not land");

	// Main scenarios the random run should reach
	COV_CAPTURE: cover property (mclk_en && |live_evt && !held_ff);
	COV_DAC: cover property (mclk_en && |live_evt && !held_ff && txn.dac);
	COV_RACE: cover property (mclk_en && |live_evt && held_ff && log_release);
	COV_SEV_WR: cover property (mclk_en && wr_sev);
	COV_TC_WR: cover property (mclk_en && wr_v0ctl && cfg_req.be[0]);
endmodule

// [tb/selvc_tb.sv]
// Self-checking bench for the secondary error log and VC capability bank.
// Assumes selvc_pkg and selvc_bank are compiled first; the bench drives every port.
`timescale 1ns/1ps
module tb;
	logic mclk; // Bench clock
	logic reset; // Synchronous reset
	logic mclk_en; // Clock enable
	selvc_pkg::selvc_cfg_req_t cfg_req; // Host request
	logic [31:0] cfg_rdata; // Read data
	logic cfg_rvalid; // Read valid pulse
	logic [13:0] err_evt; // Error pulses
	logic [13:0] err_mask; // Error masks
	selvc_pkg::selvc_txn_t txn; // Failing transaction
	logic log_release; // Status clear
	logic err_fatal; // Fatal pulse
	logic err_nonfatal; // Non-fatal pulse
	logic log_held; // Log holds an error
	integer n_mismatch = 0; // Mismatch count
	integer comparisons = 0; // Compare count
	integer seed = 32'hf500; // Random seed
	integer i; // Loop index
	integer k; // Loop index
	logic [13:0] m_sev; // Model severity
	logic [6:0] m_tc; // Model TC map 7:1
	logic [4:0] m_ptr; // Model pointer
	logic m_held; // Model log full
	logic [31:0] m_log [4]; // Model log words
	// Every mapped word plus one unmapped address past the VC block
	logic [11:0] ofs [15] = '{12'h134, 12'h138, 12'h13C, 12'h140, 12'h144, 12'h148,
		12'h14C, 12'h150, 12'h154, 12'h158, 12'h15C, 12'h160, 12'h164, 12'h168, 12'h16C};

	selvc_bank dut (.mclk(mclk), .reset(reset), .mclk_en(mclk_en), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .err_evt(err_evt),
		.err_mask(err_mask), .txn(txn), .log_release(log_release),
		.err_fatal(err_fatal), .err_nonfatal(err_nonfatal), .log_held(log_held));

	// Free-running 50 ns clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Expected read data, built from the model state
	function automatic logic [31:0] exp_rd(input logic [11:0] a);
		case (a)
			12'h134: exp_rd = {18'h0_0000, m_sev};
			12'h138: exp_rd = {27'h000_0000, m_ptr};
			12'h13C: exp_rd = m_log[0];
			12'h140: exp_rd = m_log[1];
			12'h144: exp_rd = m_log[2];
			12'h148: exp_rd = m_log[3];
			12'h150: exp_rd = 32'h0001_0002;
			12'h164: exp_rd = {1'b1, 23'h00_0000, m_tc, 1'b1};
			default: exp_rd = 32'h0000_0000; // Fixed zero and unmapped words
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Read strobe for one cycle; valid and data land one edge later
	task automatic rd(input logic [11:0] a);
		@(posedge mclk);
		cfg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'h0, wdata: 32'h0000_0000};
		@(posedge mclk);
		cfg_req.rd <= 1'b0;
		#1;
		chk("rvalid", 32'h0000_0001, {31'h0, cfg_rvalid});
		chk("rdata", exp_rd(a), cfg_rdata);
	endtask

	// Write strobe for one cycle; model follows only if upd is set
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
		input logic upd);
		@(posedge mclk);
		cfg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
		@(posedge mclk);
		cfg_req.wr <= 1'b0;
		if (upd && a == 12'h134 && be[0]) m_sev[7:0] = d[7:0] & 8'hEF;
		if (upd && a == 12'h134 && be[1]) m_sev[13:8] = d[13:8];
		if (upd && a == 12'h164 && be[0]) m_tc = d[7:1];
	endtask

	// One error event cycle with random transaction fields
	task automatic err_step(input logic [13:0] evt, input logic [13:0] msk, input logic rel);
		logic [13:0] h;
		@(posedge mclk);
		err_evt <= evt;
		err_mask <= msk;
		log_release <= rel;
		txn <= selvc_pkg::selvc_txn_t'(109'({$random(seed), $random(seed), $random(seed),
			$random(seed)}));
		h = evt & ~msk & 14'h3FEF;
		@(posedge mclk);
		err_evt <= 14'h0;
		log_release <= 1'b0;
		#1;
		chk("fatal", {31'h0, |(h & m_sev)}, {31'h0, err_fatal});
		chk("nonfatal", {31'h0, |(h & ~m_sev)}, {31'h0, err_nonfatal});
		if (rel) m_held = 1'b0;
		// Capture wins over a release in the same cycle
		if (h != 14'h0 && !m_held) begin
			m_held = 1'b1;
			for (k = 13; k >= 0; k--) if (h[k]) m_ptr = k[4:0];
			m_log[0] = txn.attr_ad;
			m_log[1] = {20'h0_0000, txn.dac ? txn.cmd_hi : 4'h0, txn.cmd_lo, txn.attr_cbe};
			m_log[2] = txn.addr_lo;
			m_log[3] = txn.dac ? txn.addr_hi : 32'h0000_0000;
		end
		chk("held", {31'h0, m_held}, {31'h0, log_held});
	endtask

	task end_sim;
		if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Hang guard, far beyond the roughly one thousand cycles the run needs
	initial begin
		repeat (40000) @(posedge mclk);
		n_mismatch++;
		end_sim;
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		mclk_en = 1'b1;
		cfg_req = '0;
		err_evt = 14'h0;
		err_mask = 14'h0;
		txn = '0;
		log_release = 1'b0;
		m_sev = 14'h1340;
		m_tc = 7'h7F;
		m_ptr = 5'h0;
		m_held = 1'b0;
		for (i = 0; i < 4; i++) m_log[i] = 32'h0000_0000;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		// Reset values of every word
		for (i = 0; i < 15; i++) rd(ofs[i]);
		// All ones everywhere: only writable bits may move
		for (i = 0; i < 15; i++) wr(ofs[i], 32'hFFFF_FFFF, 4'hF, 1'b1);
		for (i = 0; i < 15; i++) rd(ofs[i]);
		// Random writes with random byte enables to the two writable words
		for (i = 0; i < 24; i++) begin
			wr(i[0] ? 12'h164 : 12'h134, $random(seed), 4'($random(seed)), 1'b1);
			rd(i[0] ? 12'h164 : 12'h134);
		end
		// A write while the clock enable is low must not land
		@(posedge mclk);
		mclk_en <= 1'b0;
		wr(12'h134, 32'h0000_0000, 4'hF, 1'b0);
		mclk_en <= 1'b1;
		rd(12'h134);
		// Error events, masks and releases mixed with log reads
		for (i = 0; i < 160; i++) begin
			err_step(14'($random(seed)), 14'($random(seed)), ($random(seed) & 3) == 0);
			if (i % 4 == 3) for (k = 1; k < 6; k++) rd(ofs[k]);
			if (i % 16 == 15) wr(12'h134, $random(seed), 4'h3, 1'b1);
		end
		// Second reset in mid-run: captured log and written bits must all return
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		m_sev = 14'h1340;
		m_tc = 7'h7F;
		m_ptr = 5'h00;
		m_held = 1'b0;
		for (i = 0; i < 4; i++) m_log[i] = 32'h0000_0000;
		#1;
		chk("held", 32'h0000_0000, {31'h0, log_held});
		for (i = 0; i < 15; i++) rd(ofs[i]);
		end_sim;
	end
endmodule
